// ==== logic/serial_cfg_pkg.sv ====
// Shared constants, types and structs for the serial configuration port
package serial_cfg_pkg;
   localparam int CLK_PERIOD_NS = 100;
   // Delayed sampling after a clock rise, and drive update after a fall
   localparam int RISE_DELAY_NS = 100;
   localparam int FALL_DELAY_NS = 100;
   localparam int RISE_CYC_I = (RISE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int FALL_CYC_I = (FALL_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [3:0] RISE_CYC = (RISE_CYC_I < 1) ? 4'h1 : 4'(RISE_CYC_I);
   localparam logic [3:0] FALL_CYC = (FALL_CYC_I < 1) ? 4'h1 : 4'(FALL_CYC_I);

   localparam logic [4:0] ADDR_FIXED = 5'h11;
   localparam int REG_COUNT = 28;
   localparam logic [7:0] OUT_CFG_REG = 8'h01;
   localparam int OUT_CFG_BIT = 0;
   localparam logic OUT_CFG_RESET = 1'b0;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;

   // Common-mode comparator level codes
   localparam logic [1:0] CM_2V0 = 2'h0;
   localparam logic [1:0] CM_2V5 = 2'h1;
   localparam logic [1:0] CM_3V0 = 2'h2;

   typedef enum logic [3:0] {
      PH_IDLE = 4'h0,
      PH_ADDR = 4'h1,
      PH_ADDR_ACK = 4'h2,
      PH_PTR = 4'h3,
      PH_PTR_ACK = 4'h4,
      PH_WDATA = 4'h5,
      PH_WDATA_ACK = 4'h6,
      PH_RDATA = 4'h7,
      PH_RACK = 4'h8
   } phase_t;

   typedef struct packed {
      logic [1:0] red;
      logic [1:0] green;
      logic [1:0] blue;
   } cm_levels_t;

   typedef struct packed {
      logic en;
      logic [7:0] addr;
      logic [7:0] data;
   } reg_write_t;
endpackage

// ==== logic/pin_sync.sv ====
// Two-stage synchroniser for asynchronous inputs
`timescale 1ns/100ps
module pin_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic i_mclk,
   input wire logic i_resetn,
   input wire logic [W-1:0] i_d,
   output logic [W-1:0] o_q
);
   typedef struct packed {
      logic [W-1:0] first;
      logic [W-1:0] second;
   } sync_st_t;

   sync_st_t st;
   sync_st_t next_st;

   // First stage feeds only the second stage
   always_comb begin
      next_st.first = i_d;
      next_st.second = st.first;
   end

   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         // Both stages reset to the pin's idle level, so no false edge follows reset
         st <= {RST_VAL, RST_VAL};
      end else begin
         st <= next_st;
      end
   end

   assign o_q = st.second;
endmodule

// ==== logic/cfg_reg_store.sv ====
// Configuration register storage with registered read data
`timescale 1ns/100ps
module cfg_reg_store #(
   parameter int DEPTH = serial_cfg_pkg::REG_COUNT
) (
   input wire logic i_mclk,
   input wire logic i_resetn,
   input wire serial_cfg_pkg::reg_write_t i_wr,
   input wire logic [7:0] i_raddr,
   output logic [7:0] o_rdata
);
   typedef struct packed {
      logic [DEPTH-1:0][7:0] mem;
      logic [7:0] rdata;
   } store_st_t;

   store_st_t st;
   store_st_t next_st;

   always_comb begin
      next_st = st;
      for (int i = 0; i < DEPTH; i++) begin
         if (i_wr.en && i_wr.addr == 8'(i)) begin
            next_st.mem[i] = i_wr.data;
         end
      end
      // Unmapped pointer values read as zero
      next_st.rdata = 8'h00;
      for (int i = 0; i < DEPTH; i++) begin
         if (i_raddr == 8'(i)) begin
            next_st.rdata = st.mem[i];
         end
      end
   end

   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign o_rdata = st.rdata;
endmodule

// ==== logic/serial_config_port_sync_decode.sv ====
// Two-wire configuration target port with common-mode sync decoder
// Function
// - Target address is 10001, then high strap, then low strap.
// - Address compare uses present strap pin levels, so strap changes move the address.
// - Host drives clock; data line is open-drain, only pulled low or released.
// - Both lines watched always; everything ignored until a start is seen.
// - Address byte is seven address bits then direction, one meaning read.
// - Matching address is acknowledged by pulling data low; others stay silent.
// - Byte after a write address loads the register pointer before any data.
// - Pointer increments after every data byte read or written.
// - Register 0x01 bit 0 selects output mode: zero sync decode, one pass-through.
// - Decode mode: hsync on red pin, vsync on green, blue held low.
// - Common-mode levels map to hsync and vsync per the four-row table.
// - Pass-through mode copies the three common-mode levels to the outputs.
// - Transfer ends at stop or repeated start; repeated start may reverse direction.
// - Write data sampled after delayed clock rise; read data changes after clock fall.
`timescale 1ns/100ps
module serial_config_port_sync_decode (
   input wire logic i_mclk,
   input wire logic i_resetn,
   input wire logic i_scl,
   input wire logic i_sda,
   output logic o_sda_out,
   output logic o_sda_oe_n,
   input wire logic i_addr_strap_low_pin,
   input wire logic i_addr_strap_high_pin,
   input wire serial_cfg_pkg::cm_levels_t i_cm_level,
   output logic [1:0] o_hsync_or_red_cm_out,
   output logic [1:0] o_vsync_or_green_cm_out,
   output logic [1:0] o_blue_cm_out
);
   typedef struct packed {
      serial_cfg_pkg::phase_t ph;
      logic scl_d;
      logic sda_d;
      logic [3:0] rise_cnt;
      logic [3:0] fall_cnt;
      logic [3:0] bit_cnt;
      logic [7:0] sh;
      logic [7:0] ptr;
      logic rw;
      logic nack;
      logic sda_oe_n;
      logic sda_out;
      logic pass_mode;
      serial_cfg_pkg::reg_write_t wr;
      serial_cfg_pkg::cm_levels_t cm_prev;
      logic hsync;
      logic vsync;
      logic [1:0] red_out;
      logic [1:0] green_out;
      logic [1:0] blue_out;
   } port_st_t;

   port_st_t st;
   port_st_t next_st;

   logic scl_s;
   logic sda_s;
   logic strap_lo;
   logic strap_hi;
   serial_cfg_pkg::cm_levels_t cm_s;
   logic [7:0] rdata;

   // Bus lines reset to their idle high level, so no false edge follows reset
   pin_sync #(
      .W(2),
      .RST_VAL(2'h3)
   ) u_bus_sync (
      .i_mclk(i_mclk),
      .i_resetn(i_resetn),
      .i_d({i_scl, i_sda}),
      .o_q({scl_s, sda_s})
   );

   // Straps may move at any time; the compare follows them
   pin_sync #(
      .W(2),
      .RST_VAL(2'h0)
   ) u_strap_sync (
      .i_mclk(i_mclk),
      .i_resetn(i_resetn),
      .i_d({i_addr_strap_low_pin, i_addr_strap_high_pin}),
      .o_q({strap_lo, strap_hi})
   );

   // Comparator outputs are asynchronous to the core clock
   pin_sync #(
      .W(6)
   ) u_cm_sync (
      .i_mclk(i_mclk),
      .i_resetn(i_resetn),
      .i_d(i_cm_level),
      .o_q(cm_s)
   );

   cfg_reg_store #(
      .DEPTH(serial_cfg_pkg::REG_COUNT)
   ) u_regs (
      .i_mclk(i_mclk),
      .i_resetn(i_resetn),
      .i_wr(st.wr),
      .i_raddr(st.ptr),
      .o_rdata(rdata)
   );

   logic start_ev;
   logic stop_ev;
   logic rise_ev;
   logic fall_ev;
   logic addr_hit;
   logic byte_done;

   always_comb begin
      next_st = st;
      next_st.scl_d = scl_s;
      next_st.sda_d = sda_s;
      next_st.wr.en = 1'b0;

      start_ev = scl_s && st.scl_d && st.sda_d && !sda_s;
      stop_ev = scl_s && st.scl_d && !st.sda_d && sda_s;
      rise_ev = (st.rise_cnt == 4'h1);
      fall_ev = (st.fall_cnt == 4'h1);
      byte_done = (st.bit_cnt == serial_cfg_pkg::BITS_PER_BYTE);
      // Straps read live at compare time
      addr_hit = (st.sh[7:1] == {serial_cfg_pkg::ADDR_FIXED, strap_hi, strap_lo});

      // Rise delay counter restarts on each bus clock rise, fall delay counter on each fall
      if (scl_s && !st.scl_d) begin
         next_st.rise_cnt = serial_cfg_pkg::RISE_CYC;
      end else if (st.rise_cnt != 4'h0) begin
         next_st.rise_cnt = st.rise_cnt - 4'h1;
      end
      if (!scl_s && st.scl_d) begin
         next_st.fall_cnt = serial_cfg_pkg::FALL_CYC;
      end else if (st.fall_cnt != 4'h0) begin
         next_st.fall_cnt = st.fall_cnt - 4'h1;
      end

      if (start_ev) begin
         // Partial byte is dropped; no write is issued
         next_st.ph = serial_cfg_pkg::PH_ADDR;
         next_st.bit_cnt = 4'h0;
         next_st.sda_oe_n = 1'b1;
         next_st.rise_cnt = 4'h0;
         next_st.fall_cnt = 4'h0;
      end else if (stop_ev) begin
         next_st.ph = serial_cfg_pkg::PH_IDLE;
         next_st.sda_oe_n = 1'b1;
      end else begin
         unique case (st.ph)
            serial_cfg_pkg::PH_IDLE: begin
               next_st.sda_oe_n = 1'b1;
            end
            serial_cfg_pkg::PH_ADDR,
            serial_cfg_pkg::PH_PTR,
            serial_cfg_pkg::PH_WDATA: begin
               if (rise_ev && !byte_done) begin
                  next_st.sh = {st.sh[6:0], sda_s};
                  next_st.bit_cnt = st.bit_cnt + 4'h1;
               end else if (fall_ev && byte_done) begin
                  next_st.bit_cnt = 4'h0;
                  next_st.sda_oe_n = 1'b0;
                  if (st.ph == serial_cfg_pkg::PH_ADDR) begin
                     if (addr_hit) begin
                        next_st.rw = st.sh[0];
                        next_st.ph = serial_cfg_pkg::PH_ADDR_ACK;
                     end else begin
                        // Silent on a miss, wait for next start
                        next_st.sda_oe_n = 1'b1;
                        next_st.ph = serial_cfg_pkg::PH_IDLE;
                     end
                  end else if (st.ph == serial_cfg_pkg::PH_PTR) begin
                     next_st.ptr = st.sh;
                     next_st.ph = serial_cfg_pkg::PH_PTR_ACK;
                  end else begin
                     next_st.wr.en = 1'b1;
                     next_st.wr.addr = st.ptr;
                     next_st.wr.data = st.sh;
                     if (st.ptr == serial_cfg_pkg::OUT_CFG_REG) begin
                        next_st.pass_mode = st.sh[serial_cfg_pkg::OUT_CFG_BIT];
                     end
                     next_st.ptr = st.ptr + 8'h01;
                     next_st.ph = serial_cfg_pkg::PH_WDATA_ACK;
                  end
               end
            end
            serial_cfg_pkg::PH_ADDR_ACK: begin
               if (fall_ev) begin
                  if (st.rw) begin
                     next_st.sh = rdata;
                     next_st.sda_oe_n = rdata[7];
                     next_st.ptr = st.ptr + 8'h01;
                     next_st.ph = serial_cfg_pkg::PH_RDATA;
                  end else begin
                     next_st.sda_oe_n = 1'b1;
                     next_st.ph = serial_cfg_pkg::PH_PTR;
                  end
               end
            end
            serial_cfg_pkg::PH_PTR_ACK,
            serial_cfg_pkg::PH_WDATA_ACK: begin
               if (fall_ev) begin
                  next_st.sda_oe_n = 1'b1;
                  next_st.ph = serial_cfg_pkg::PH_WDATA;
               end
            end
            serial_cfg_pkg::PH_RDATA: begin
               if (rise_ev) begin
                  next_st.bit_cnt = st.bit_cnt + 4'h1;
               end else if (fall_ev) begin
                  // Drive changes only after the falling edge
                  if (byte_done) begin
                     next_st.sda_oe_n = 1'b1;
                     next_st.bit_cnt = 4'h0;
                     next_st.ph = serial_cfg_pkg::PH_RACK;
                  end else begin
                     next_st.sh = {st.sh[6:0], 1'b0};
                     next_st.sda_oe_n = st.sh[6];
                  end
               end
            end
            serial_cfg_pkg::PH_RACK: begin
               if (rise_ev) begin
                  next_st.nack = sda_s;
               end else if (fall_ev) begin
                  if (st.nack) begin
                     next_st.ph = serial_cfg_pkg::PH_IDLE;
                  end else begin
                     next_st.sh = rdata;
                     next_st.sda_oe_n = rdata[7];
                     next_st.ptr = st.ptr + 8'h01;
                     next_st.ph = serial_cfg_pkg::PH_RDATA;
                  end
               end
            end
            default: begin
               next_st.ph = serial_cfg_pkg::PH_IDLE;
               next_st.sda_oe_n = 1'b1;
            end
         endcase
      end

      // Decode only on a level code seen twice, to skip comparator skew
      next_st.cm_prev = cm_s;
      if (cm_s == st.cm_prev) begin
         unique case (cm_s)
            {serial_cfg_pkg::CM_2V5, serial_cfg_pkg::CM_3V0, serial_cfg_pkg::CM_2V0}: begin
               next_st.hsync = 1'b0;
               next_st.vsync = 1'b0;
            end
            {serial_cfg_pkg::CM_3V0, serial_cfg_pkg::CM_2V0, serial_cfg_pkg::CM_2V5}: begin
               next_st.hsync = 1'b0;
               next_st.vsync = 1'b1;
            end
            {serial_cfg_pkg::CM_2V0, serial_cfg_pkg::CM_3V0, serial_cfg_pkg::CM_2V5}: begin
               next_st.hsync = 1'b1;
               next_st.vsync = 1'b0;
            end
            {serial_cfg_pkg::CM_2V5, serial_cfg_pkg::CM_2V0, serial_cfg_pkg::CM_3V0}: begin
               next_st.hsync = 1'b1;
               next_st.vsync = 1'b1;
            end
            // Unlisted level mixes keep the last decoded syncs
            default: begin
               next_st.hsync = st.hsync;
               next_st.vsync = st.vsync;
            end
         endcase
      end

      if (st.pass_mode) begin
         next_st.red_out = cm_s.red;
         next_st.green_out = cm_s.green;
         next_st.blue_out = cm_s.blue;
      end else begin
         next_st.red_out = {1'b0, st.hsync};
         next_st.green_out = {1'b0, st.vsync};
         next_st.blue_out = 2'h0;
      end
   end

   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         st <= '0;
         st.ph <= serial_cfg_pkg::PH_IDLE;
         st.scl_d <= 1'b1;
         st.sda_d <= 1'b1;
         st.sda_oe_n <= 1'b1;
         st.sda_out <= 1'b0;
         st.pass_mode <= serial_cfg_pkg::OUT_CFG_RESET;
      end else begin
         st <= next_st;
      end
   end

   // Open-drain: only ever drives low
   assign o_sda_out = st.sda_out;
   assign o_sda_oe_n = st.sda_oe_n;
   assign o_hsync_or_red_cm_out = st.red_out;
   assign o_vsync_or_green_cm_out = st.green_out;
   assign o_blue_cm_out = st.blue_out;
endmodule

// ==== verification/sync_port_monitor.sv ====
// Bus and sync-output checker bound to the serial configuration port
`timescale 1ns/100ps
module sync_port_monitor (
   input wire logic i_mclk,
   input wire logic i_resetn,
   input wire logic i_scl,
   input wire logic i_sda,
   input wire logic o_sda_out,
   input wire logic o_sda_oe_n,
   input wire logic i_addr_strap_low_pin,
   input wire logic i_addr_strap_high_pin,
   input wire serial_cfg_pkg::cm_levels_t i_cm_level,
   input wire logic [1:0] o_hsync_or_red_cm_out,
   input wire logic [1:0] o_vsync_or_green_cm_out,
   input wire logic [1:0] o_blue_cm_out
);
   logic row_ok;
   logic [1:0] exp_hv;
   logic [5:0] outs;
   logic [5:0] dec;
   assign outs = {o_hsync_or_red_cm_out, o_vsync_or_green_cm_out, o_blue_cm_out};
   assign dec = {1'b0, exp_hv[1], 1'b0, exp_hv[0], 2'h0};
   always_comb begin
      row_ok = 1'b1;
      exp_hv = 2'h0;
      case (i_cm_level)
         6'h18: exp_hv = 2'h0;
         6'h21: exp_hv = 2'h1;
         6'h09: exp_hv = 2'h2;
         6'h12: exp_hv = 2'h3;
         default: row_ok = 1'b0;
      endcase
   end
   default clocking mon_cb @(posedge i_mclk);
   endclocking
   default disable iff (!i_resetn);
   // Levels pass a synchroniser and a stability check before decode
   sequence cm_settled;
      $stable(i_cm_level) [*8];
   endsequence
   sequence drive_begins;
      $fell(o_sda_oe_n);
   endsequence
   open_drain_low_a: assert property (!o_sda_oe_n |-> o_sda_out == 1'b0)
      else $error("data pin driven high");
   drive_held_a: assert property (drive_begins |-> !o_sda_oe_n [*6])
      else $error("data pull too short");
   edge_after_fall_a: assert property ($changed(o_sda_oe_n) |-> !$past(i_scl, 3))
      else $error("data changed near clock high");
   idle_release_a: assert property (i_scl [*8] |-> o_sda_oe_n)
      else $error("data held on idle bus");
   code_range_a: assert property (outs[5:4] != 2'h3 && outs[3:2] != 2'h3 && outs[1:0] != 2'h3)
      else $error("output code out of range");
   sync_map_a: assert property (cm_settled ##0 row_ok |-> outs == dec || outs == i_cm_level)
      else $error("sync decode mismatch");
   pass_copy_a: assert property (cm_settled ##0 o_blue_cm_out != 2'h0 |-> outs == i_cm_level)
      else $error("pass-through mismatch");
   blue_decode_a: assert property (cm_settled ##0 row_ok ##0 o_blue_cm_out != i_cm_level.blue |-> outs == dec)
      else $error("decode pin mapping wrong");
endmodule
bind serial_config_port_sync_decode sync_port_monitor mon (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_scl(i_scl),
   .i_sda(i_sda), .o_sda_out(o_sda_out), .o_sda_oe_n(o_sda_oe_n), .i_addr_strap_low_pin(i_addr_strap_low_pin),
   .i_addr_strap_high_pin(i_addr_strap_high_pin), .i_cm_level(i_cm_level), .o_blue_cm_out(o_blue_cm_out),
   .o_hsync_or_red_cm_out(o_hsync_or_red_cm_out), .o_vsync_or_green_cm_out(o_vsync_or_green_cm_out));

// ==== verification/host_model.sv ====
// Behavioural bus host that clocks the serial configuration port
`timescale 1ns/100ps
module host_model (
   input wire logic i_mclk,
   input wire logic i_sda,
   output logic o_scl,
   output logic o_sda_rel
);
   initial begin
      o_scl = 1'b1;
      o_sda_rel = 1'b1;
   end
   // One quarter of the 800 ns bus period per call
   task pt(input logic c, input logic d);
      o_scl = c;
      o_sda_rel = d;
      repeat (2) @(posedge i_mclk);
      #1;
   endtask
   // Pairs of clock then data, oldest first
   task wave(input logic [11:0] pat);
      for (int i = 5; i >= 0; i--) pt(pat[2*i+1], pat[2*i]);
   endtask
   task start_cond;
      wave(12'b01_11_11_10_10_00);
   endtask
   task stop_cond;
      wave(12'b00_10_10_11_11_11);
   endtask
   // Sampled late in the high phase, as the device updates after the fall
   task xbit(input logic b, output logic r);
      pt(1'b0, o_sda_rel);
      pt(1'b0, b);
      pt(1'b1, b);
      pt(1'b1, b);
      r = i_sda;
   endtask
   task xbyte(input logic [7:0] d, input logic ack_in, output logic [7:0] r, output logic ack_out);
      for (int i = 7; i >= 0; i--) xbit(d[i], r[i]);
      xbit(ack_in, ack_out);
   endtask
endmodule

// ==== verification/test_serial_config_port_sync_decode.sv ====
// Self-checking bench for the serial configuration port
`timescale 1ns/100ps
module test_serial_config_port_sync_decode;
   localparam logic [5:0] ROWS [4] = '{6'h18, 6'h21, 6'h09, 6'h12};
   localparam logic [7:0] DEC [4] = '{8'h00, 8'h04, 8'h10, 8'h14};
   localparam logic [7:0] WDAT [3] = '{8'hA5, 8'h5A, 8'h3C};
   logic mclk = 1'b0;
   logic resetn = 1'b0;
   logic strap_low = 1'b0;
   logic strap_high = 1'b0;
   serial_cfg_pkg::cm_levels_t cm = 6'h18;
   logic scl, sda_rel, sda_oe_n, sda_out, k;
   logic [1:0] hs, vs, bl;
   logic [7:0] r;
   logic [7:0] rbuf [4];
   wire sda;
   int n_mismatch = 0;
   int num_checks = 0;
   // Wired-AND; a released line floats high on its pull-up
   assign sda = sda_rel & (sda_oe_n | sda_out);
   always #50 mclk = ~mclk;
   host_model host (.i_mclk(mclk), .i_sda(sda), .o_scl(scl), .o_sda_rel(sda_rel));
   serial_config_port_sync_decode dut (.i_mclk(mclk), .i_resetn(resetn), .i_scl(scl), .i_sda(sda),
      .o_sda_out(sda_out), .o_sda_oe_n(sda_oe_n), .i_addr_strap_low_pin(strap_low),
      .i_addr_strap_high_pin(strap_high), .i_cm_level(cm), .o_hsync_or_red_cm_out(hs),
      .o_vsync_or_green_cm_out(vs), .o_blue_cm_out(bl));
   task tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   function automatic logic [6:0] dev();
      return {serial_cfg_pkg::ADDR_FIXED, strap_high, strap_low};
   endfunction
   task sel(input logic [6:0] a, input logic rw, input logic ack);
      host.start_cond();
      host.xbyte({a, rw}, 1'b1, r, k);
      chk({7'h00, k}, {7'h00, ~ack});
   endtask
   task send(input logic [7:0] d);
      host.xbyte(d, 1'b1, r, k);
      chk({7'h00, k}, 8'h00);
   endtask
   task wr(input logic [7:0] p, input logic [7:0] d);
      sel(dev(), 1'b0, 1'b1);
      send(p);
      send(d);
      host.stop_cond();
   endtask
   task rd(input logic [7:0] p, input int n);
      sel(dev(), 1'b0, 1'b1);
      send(p);
      sel(dev(), 1'b1, 1'b1);
      for (int i = 0; i < n; i++) host.xbyte(8'hFF, 1'(i == n - 1), rbuf[i], k);
      host.stop_cond();
   endtask
   task t_sync;
      for (int i = 0; i < 4; i++) begin
         cm = ROWS[i];
         tick(12);
         chk({2'h0, hs, vs, bl}, DEC[i]);
      end
      wr(8'h01, 8'h01);
      for (int i = 0; i < 4; i++) begin
         cm = ROWS[i];
         tick(12);
         chk({2'h0, hs, vs, bl}, {2'h0, ROWS[i]});
      end
      wr(8'h01, 8'h00);
      tick(12);
      chk({2'h0, hs, vs, bl}, DEC[3]);
      $display("t_sync done");
   endtask
   task t_addr;
      for (int s = 0; s < 4; s++) begin
         {strap_high, strap_low} = 2'(s);
         tick(4);
         sel(dev(), 1'b0, 1'b1);
         host.stop_cond();
         sel({serial_cfg_pkg::ADDR_FIXED, strap_high, ~strap_low}, 1'b0, 1'b0);
         host.xbyte(8'h00, 1'b1, r, k);
         chk({7'h00, k}, 8'h01);
         host.stop_cond();
      end
      {strap_high, strap_low} = 2'h0;
      tick(4);
      sel(7'h45, 1'b0, 1'b0);
      host.stop_cond();
      strap_low = 1'b1;
      tick(4);
      sel(7'h45, 1'b0, 1'b1);
      host.stop_cond();
      $display("t_addr done");
   endtask
   task t_burst;
      sel(dev(), 1'b0, 1'b1);
      send(8'h02);
      for (int i = 0; i < 3; i++) send(WDAT[i]);
      host.stop_cond();
      rd(8'h02, 3);
      for (int i = 0; i < 3; i++) chk(rbuf[i], WDAT[i]);
      $display("t_burst done");
   endtask
   task t_abort;
      sel(dev(), 1'b0, 1'b1);
      send(8'h03);
      for (int i = 0; i < 4; i++) host.xbit(1'b0, k);
      rd(8'h03, 1);
      chk(rbuf[0], WDAT[1]);
      $display("t_abort done");
   endtask
   task wrap_up;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   initial begin
      tick(16);
      resetn = 1'b1;
      tick(4);
      t_sync();
      t_addr();
      t_burst();
      t_abort();
      wrap_up();
   end
   // Whole run needs well under half of this span
   initial begin
      #2000000;
      n_mismatch++;
      $display("watchdog expired");
      wrap_up();
   end
endmodule
